/* logic/sqf_pkg.sv */
/*
  constants, types and register map of the subcode Q-channel formatter.
  assumes a single 125 MHz clock domain and an AHB-Lite register port.
*/
// Operation
// RULE1: internal mode makes P and Q, R-W zero
// RULE2: external mode takes link subcode, checks sync
// RULE3: P from level bit or frame bit 5
// RULE4: new P level taken at frame start
// RULE5: three bits select relative/absolute time action
// RULE6: copy bit held unless copy-alternate set
// RULE7: copy-alternate copies absolute frame bit 2
// RULE8: zero byte low nibble counts modulo 10
// RULE9: bank swap at first sync, counter zero
// RULE10: insert-once clear keeps original bank only
// RULE11: insert-once shows other bank once, self-clears
// RULE12: frame counter loads from reload field
// RULE13: config two read returns frame counter
// RULE14: access select picks output or other bank
// RULE15: data port access hits selected bank
// RULE16: software writes access start before block
// RULE17: Q CRC computed locally, link CRC dropped
// RULE18: byte pointer advances, access start resets
// RULE19: frame counter advances per sync, wraps
package sqf_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG1 = 8'h23;
  localparam logic [7:0] IDX_CFG2 = 8'h24;
  localparam logic [7:0] IDX_START = 8'h25;
  localparam logic [7:0] IDX_DATA = 8'h26;
  localparam logic [7:0] IDX_STAT = 8'h27;
  localparam logic [9:0] ADR_CFG1 = {IDX_CFG1, 2'h0};
  localparam logic [9:0] ADR_CFG2 = {IDX_CFG2, 2'h0};
  localparam logic [9:0] ADR_START = {IDX_START, 2'h0};
  localparam logic [9:0] ADR_DATA = {IDX_DATA, 2'h0};
  localparam logic [9:0] ADR_STAT = {IDX_STAT, 2'h0};
  // field positions
  localparam int CFG1_EXT = 7;
  localparam int CFG1_PTOG = 6;
  localparam int CFG1_PLVL = 5;
  localparam int CFG1_TA = 4;
  localparam int CFG1_TB = 3;
  localparam int CFG1_COPY = 2;
  localparam int CFG1_ZINC = 1;
  localparam int CFG1_TC = 0;
  localparam int CFG2_SWAP = 7;
  localparam int CFG2_INS = 6;
  localparam int START_SEL = 7;
  localparam int COPY_POS = 5;
  localparam int PFRM_BIT = 5;
  localparam int CFRM_BIT = 2;
  // Q-code byte layout
  localparam logic [3:0] QB_CTRL = 4'h0;
  localparam logic [3:0] QB_RMIN = 4'h3;
  localparam logic [3:0] QB_ZERO = 4'h6;
  localparam logic [3:0] QB_AMIN = 4'h7;
  localparam logic [3:0] QB_AFRM = 4'h9;
  localparam logic [3:0] QCODE_LAST = 4'h9;
  // frame geometry and codes
  localparam logic [6:0] SYNC_SYMS = 7'h02;
  localparam logic [6:0] QBITS = 7'h50;
  localparam logic [6:0] SYM_LAST = 7'h61;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [7:0] FRM_MAX = 8'h74;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h99;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;
  // time action, code is {time_ctl_c, time_ctl_b, time_ctl_a}
  typedef enum logic [2:0] {
    T_INC_BOTH = 3'b000,
    T_INC_REL = 3'b011,
    T_INC_ABS = 3'b100,
    T_DEC_REL = 3'b101,
    T_HOLD = 3'b111
  } sqf_time_type;
  // one subcode symbol toward the modulator, bit 7 is P, bit 6 is Q
  typedef struct packed {
    logic valid;
    logic [7:0] sym;
  } sqf_sym_type;
endpackage

/* logic/sqf_formatter.sv */
/*
  subcode Q-channel formatter: AHB-Lite register slave, two Q-code banks,
  per-frame time/copy/zero updates, bank insert and symbol stream out.
  assumes the modulator strobes are on this clock; link pins are async.
*/
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module sqf_formatter (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // modulator side
  input wire logic frameSync,
  input wire logic symReq,
  output sqf_pkg::sqf_sym_type symOut,
  // external record link pins
  input wire logic [7:0] extData,
  input wire logic extSync
);
  import sqf_pkg::*;

  logic pend_ff; // data phase pending
  logic [9:0] pAddr_ff; // latched address
  logic pWrite_ff; // latched direction
  logic [7:0] cfg1_ff; // config one
  logic swap_ff; // bank swap enable
  logic ins_ff; // insert other once
  logic [2:0] reload_ff; // frame counter reload
  logic [2:0] cnt_ff; // subcode frame counter
  logic sel_ff; // bank access select
  logic [3:0] ptr_ff; // Q-code byte pointer
  logic insAct_ff; // other bank on output this frame
  logic pLat_ff; // P level for current frame
  logic errFlag_ff; // link sync error, sticky
  logic [6:0] pos_ff; // symbol position in frame
  logic [15:0] crc_ff; // running Q CRC
  logic [7:0] extD1_ff, extD2_ff; // link data sync
  logic extS1_ff, extS2_ff; // link sync sync
  logic [7:0] qMem [2][10]; // bank 0 original, bank 1 other
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  sqf_sym_type symOut_ff;

  logic take, doWr, doRd, wrCfg1, wrCfg2, wrStart, wrStat, dataAcc;
  logic extMode, busBank, frameUpd, pBit, qBit, intQ, inQ, inCrc;
  logic [6:0] qIdx;
  logic [7:0] rdMux, nxtSym;
  sqf_time_type tAct;
  logic [23:0] relTime, absTime; // bank 0 time fields, min/sec/frame

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign symOut = symOut_ff;

  // bus decode; hsize ignored since only whole words are used
  assign take = hsel && htrans[1] && hready;
  assign doWr = pend_ff && pWrite_ff;
  assign doRd = pend_ff && !pWrite_ff;
  assign wrCfg1 = doWr && (pAddr_ff == ADR_CFG1);
  assign wrCfg2 = doWr && (pAddr_ff == ADR_CFG2);
  assign wrStart = doWr && (pAddr_ff == ADR_START);
  assign wrStat = doWr && (pAddr_ff == ADR_STAT);
  assign dataAcc = pend_ff && (pAddr_ff == ADR_DATA);
  assign extMode = cfg1_ff[CFG1_EXT];
  assign busBank = sel_ff ? insAct_ff : !insAct_ff; // RULE14
  assign frameUpd = frameSync && !extMode; // RULE2
  assign tAct = sqf_time_type'({cfg1_ff[CFG1_TC], cfg1_ff[CFG1_TB], cfg1_ff[CFG1_TA]}); // RULE5
  // time fields of the original bank, read by the frame update
  assign relTime = {qMem[0][QB_RMIN], qMem[0][QB_RMIN + 4'h1], qMem[0][QB_RMIN + 4'h2]};
  assign absTime = {qMem[0][QB_AMIN], qMem[0][QB_AMIN + 4'h1], qMem[0][QB_AMIN + 4'h2]};

  // read mux; write-only registers read zero
  always_comb begin
    rdMux = 8'h00;
    unique case (pAddr_ff)
      ADR_CFG2: rdMux = {swap_ff, ins_ff, reload_ff, cnt_ff}; // RULE13
      ADR_DATA: rdMux = qMem[busBank][ptr_ff]; // RULE15
      ADR_STAT: rdMux = {6'h00, insAct_ff, errFlag_ff};
      default: rdMux = 8'h00;
    endcase
  end

  // every access takes one wait state so pointer and data stay ordered
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      pAddr_ff <= 10'h000;
      pWrite_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
    end else begin
      pend_ff <= take;
      hreadyout_ff <= !take;
      if (take) begin
        pAddr_ff <= haddr[9:0];
        pWrite_ff <= hwrite;
      end
      if (doRd) begin
        hrdata_ff <= {24'h000000, rdMux};
      end
    end
  end

  // config one and P level latch
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg1_ff <= CFG1_RST;
      pLat_ff <= 1'b0;
    end else begin
      if (wrCfg1) begin
        cfg1_ff <= hwdata[7:0];
      end
      if (frameSync) begin
        pLat_ff <= cfg1_ff[CFG1_PLVL]; // RULE4
      end
    end
  end

  // config two, frame counter and bank insert
  always_ff @(posedge clock) begin
    if (!nrst) begin
      swap_ff <= 1'b0;
      ins_ff <= 1'b0;
      reload_ff <= CNT_RST;
      cnt_ff <= CNT_RST;
      insAct_ff <= 1'b0;
    end else begin
      if (frameSync) begin
        cnt_ff <= cnt_ff + 3'h1; // RULE19
        // insert lasts exactly one frame, then the original returns
        insAct_ff <= swap_ff && ins_ff && (cnt_ff == 3'h0); // RULE9 RULE10
        if (swap_ff && ins_ff && (cnt_ff == 3'h0)) begin
          ins_ff <= 1'b0; // RULE11
        end
      end
      // software write wins over the self-clear
      if (wrCfg2) begin
        swap_ff <= hwdata[CFG2_SWAP];
        ins_ff <= hwdata[CFG2_INS];
        reload_ff <= hwdata[5:3];
        cnt_ff <= hwdata[5:3]; // RULE12
      end
    end
  end

  // access select and byte pointer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sel_ff <= 1'b0;
      ptr_ff <= 4'h0;
    end else if (wrStart) begin
      sel_ff <= hwdata[START_SEL]; // RULE14
      ptr_ff <= 4'h0; // RULE18
    end else if (dataAcc) begin
      ptr_ff <= (ptr_ff == QCODE_LAST) ? 4'h0 : ptr_ff + 4'h1; // RULE18
    end
  end

  // link pins pass two flops before use
  always_ff @(posedge clock) begin
    if (!nrst) begin
      extD1_ff <= 8'h00;
      extD2_ff <= 8'h00;
      extS1_ff <= 1'b0;
      extS2_ff <= 1'b0;
    end else begin
      extD1_ff <= extData;
      extD2_ff <= extD1_ff;
      extS1_ff <= extSync;
      extS2_ff <= extS1_ff;
    end
  end

  // link sync check; a new error beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      errFlag_ff <= 1'b0;
    end else if (frameSync && extMode && !extS2_ff) begin
      errFlag_ff <= 1'b1; // RULE2
    end else if (wrStat && hwdata[0]) begin
      errFlag_ff <= 1'b0;
    end
  end

  function automatic logic [7:0] bcdInc(input logic [7:0] b);
    bcdInc = (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
  endfunction

  function automatic logic [7:0] bcdDec(input logic [7:0] b);
    bcdDec = (b[3:0] == 4'h0) ? {b[7:4] - 4'h1, 4'h9} : b - 8'h01;
  endfunction

  // min/sec/frame step in BCD, up or down with carry
  function automatic logic [23:0] timeStep(input logic [23:0] t, input logic dn);
    logic [7:0] m, s, f;
    m = t[23:16];
    s = t[15:8];
    f = t[7:0];
    if (!dn) begin
      if (f != FRM_MAX) begin
        f = bcdInc(f);
      end else begin
        f = 8'h00;
        if (s != SEC_MAX) begin
          s = bcdInc(s);
        end else begin
          s = 8'h00;
          m = (m == MIN_MAX) ? 8'h00 : bcdInc(m);
        end
      end
    end else begin
      if (f != 8'h00) begin
        f = bcdDec(f);
      end else begin
        f = FRM_MAX;
        if (s != 8'h00) begin
          s = bcdDec(s);
        end else begin
          s = SEC_MAX;
          m = (m == 8'h00) ? MIN_MAX : bcdDec(m);
        end
      end
    end
    timeStep = {m, s, f};
  endfunction

  // Q-code memory: frame updates on the original bank, bus writes last
  always_ff @(posedge clock) begin
    if (frameUpd) begin
      if (tAct == T_INC_BOTH || tAct == T_INC_REL || tAct == T_DEC_REL) begin
        {qMem[0][QB_RMIN], qMem[0][QB_RMIN + 4'h1], qMem[0][QB_RMIN + 4'h2]}
          <= timeStep(relTime, tAct == T_DEC_REL); // RULE5
      end
      if (tAct == T_INC_BOTH || tAct == T_INC_ABS || tAct == T_DEC_REL) begin
        {qMem[0][QB_AMIN], qMem[0][QB_AMIN + 4'h1], qMem[0][QB_AMIN + 4'h2]}
          <= timeStep(absTime, 1'b0); // RULE5
      end
      // copy bit untouched unless alternating
      if (cfg1_ff[CFG1_COPY]) begin
        qMem[0][QB_CTRL][COPY_POS] <= qMem[0][QB_AFRM][CFRM_BIT]; // RULE7 RULE6
      end
      if (cfg1_ff[CFG1_ZINC]) begin
        qMem[0][QB_ZERO][3:0] <= (qMem[0][QB_ZERO][3:0] == 4'h9) ? 4'h0
          : qMem[0][QB_ZERO][3:0] + 4'h1; // RULE8
      end
    end
    if (dataAcc && pWrite_ff) begin
      qMem[busBank][ptr_ff] <= hwdata[7:0]; // RULE15 RULE6
    end
  end

  // symbol composition
  assign qIdx = pos_ff - SYNC_SYMS;
  assign inQ = (pos_ff >= SYNC_SYMS) && (qIdx < QBITS);
  assign inCrc = (pos_ff >= SYNC_SYMS) && (qIdx >= QBITS);
  assign intQ = qMem[insAct_ff][qIdx[6:3]][~qIdx[2:0]];
  assign pBit = cfg1_ff[CFG1_PTOG] ? qMem[insAct_ff][QB_AFRM][PFRM_BIT] : pLat_ff; // RULE3
  // link CRC bits are dropped and replaced by the local one
  assign qBit = inQ ? (extMode ? extD2_ff[6] : intQ) : (inCrc && !crc_ff[15]); // RULE17

  always_comb begin
    nxtSym = 8'h00;
    if (inQ || inCrc) begin
      nxtSym = extMode ? {extD2_ff[7], qBit, extD2_ff[5:0]} // RULE2
        : {pBit, qBit, 6'h00}; // RULE1
    end
  end

  // position, CRC and output symbol
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pos_ff <= 7'h00;
      crc_ff <= 16'h0000;
      symOut_ff <= '0;
    end else if (frameSync) begin
      pos_ff <= 7'h00;
      crc_ff <= 16'h0000;
      symOut_ff <= '0;
    end else begin
      symOut_ff.valid <= symReq;
      if (symReq) begin
        symOut_ff.sym <= nxtSym;
        pos_ff <= (pos_ff == SYM_LAST) ? pos_ff : pos_ff + 7'h01;
        if (inQ) begin
          crc_ff <= {crc_ff[14:0], 1'b0} ^ ((crc_ff[15] ^ qBit) ? CRC_POLY : 16'h0000); // RULE17
        end else if (inCrc) begin
          crc_ff <= {crc_ff[14:0], 1'b0};
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence busAddr;
    take;
  endsequence
  sequence busWait;
    !hreadyout ##1 hreadyout;
  endsequence

  bus_wait_a: assert property (busAddr |=> busWait)
    else $error("bus answer not one wait state");
  rw_zero_a: assert property (symReq && !frameSync && !extMode |=> symOut.sym[5:0] == 6'h00) // RULE1
    else $error("R-W not zero in internal mode");
  p_hold_a: assert property (!frameSync |=> $stable(pLat_ff)) // RULE4
    else $error("P level changed mid frame");
  ins_clear_a: assert property (frameSync && swap_ff && ins_ff && cnt_ff == 3'h0 && !wrCfg2
    |=> !ins_ff && insAct_ff ##1 (frameSync || insAct_ff)) // RULE11
    else $error("insert once not taken or not cleared");
  no_swap_a: assert property (frameSync && !swap_ff |=> !insAct_ff) // RULE9
    else $error("bank switched while swap disabled");
  cnt_step_a: assert property (frameSync && !wrCfg2 |=> cnt_ff == $past(cnt_ff) + 3'h1) // RULE19
    else $error("frame counter did not advance");
  cnt_load_a: assert property (wrCfg2 |=> cnt_ff == $past(hwdata[5:3])) // RULE12
    else $error("frame counter not loaded");
  ptr_reset_a: assert property (wrStart |=> ptr_ff == 4'h0) // RULE18
    else $error("pointer not reset by access start");
  cnt_read_a: assert property (doRd && pAddr_ff == ADR_CFG2 |=> hrdata[2:0] == $past(cnt_ff)) // RULE13
    else $error("config two read lacks counter");
  err_set_a: assert property (frameSync && extMode && !extS2_ff |=> errFlag_ff) // RULE2
    else $error("link sync error not flagged");
  err_clear_a: assert property (wrStat && hwdata[0] && !(frameSync && extMode && !extS2_ff)
    |=> !errFlag_ff)
    else $error("link sync error not cleared");
  copy_hold_a: assert property (frameUpd && !cfg1_ff[CFG1_COPY] && !dataAcc // RULE6
    |=> $stable(qMem[0][QB_CTRL]))
    else $error("copy bit changed while not alternating");
  zero_wrap_a: assert property (frameUpd && cfg1_ff[CFG1_ZINC] && !dataAcc // RULE8
    && qMem[0][QB_ZERO][3:0] == 4'h9 |=> qMem[0][QB_ZERO][3:0] == 4'h0)
    else $error("zero byte nibble did not wrap at ten");
  ext_hold_a: assert property (frameSync && extMode && !dataAcc // RULE2
    |=> $stable(qMem[0][QB_AFRM]))
    else $error("frame update ran in external mode");
endmodule // sqf_formatter

/* tb/sqf_mod_model.sv */
/*
  stand-in for the modulator: a frame sync pulse, then 98 symbol
  requests, capturing every returned symbol for the bench to inspect.
  assumes the formatter runs on the same clock and answers one cycle later.
*/
`timescale 1ns/1ps
module sqf_mod_model (
  // clock
  input wire logic clock,
  // strobes toward the formatter
  output logic frameSync,
  output logic symReq,
  // symbol stream back
  input wire sqf_pkg::sqf_sym_type symOut
);
  import sqf_pkg::*;
  logic [7:0] syms [98]; // symbols of the last frame
  // quiet strobes from time zero
  initial begin
    frameSync = 1'b0;
    symReq = 1'b0;
  end
  // one frame; gap adds idle cycles so slow requesters are covered too
  task automatic frame(input int gap);
    @(posedge clock) frameSync <= 1'b1;
    @(posedge clock) frameSync <= 1'b0;
    for (int i = 0; i < 98; i++) begin
      symReq <= 1'b1;
      @(posedge clock) symReq <= 1'b0;
      // a missing valid stores unknowns so the later compare fails
      #1 syms[i] = (symOut.valid === 1'b1) ? symOut.sym : 8'hXX;
      repeat (gap) @(posedge clock);
      @(posedge clock);
    end
  endtask
endmodule // sqf_mod_model

/* tb/subcode_q_channel_formatter_tb.sv */
/*
  self-checking bench: register accesses over AHB-Lite, frames through
  the modulator model, expectations worked out from the bank contents.
  assumes one 125 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin numErrors++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module subcode_q_channel_formatter_tb;
  import sqf_pkg::*;
  // clock, reset and bus master signals
  logic clock = 1'b0;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  // modulator and link signals
  logic frameSync;
  logic symReq;
  sqf_sym_type symOut;
  logic [7:0] extData;
  logic extSync;
  // bookkeeping
  int numErrors = 0;
  int nCompared = 0;
  logic [7:0] got [10]; // bank read back
  logic [31:0] rdv;
  logic [15:0] crc;
  logic [7:0] bankA [10] = '{8'h00, 8'hA5, 8'h01, 8'h00, 8'h00, 8'h05, 8'h37, 8'h00, 8'h02, 8'h04};
  logic [7:0] bankB [10] = '{8'h00, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [2:0] codes [5] = '{3'b000, 3'b011, 3'b100, 3'b101, 3'b111};
  logic [7:0] expRel [5] = '{8'h06, 8'h07, 8'h07, 8'h06, 8'h06};
  logic [7:0] expAbs [5] = '{8'h05, 8'h05, 8'h06, 8'h07, 8'h07};
  logic [7:0] expZero [5] = '{8'h38, 8'h39, 8'h30, 8'h31, 8'h32};
  // free-running clock, 8 ns period
  always #4 clock = ~clock;
  sqf_formatter i_dut (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frameSync(frameSync),
    .symReq(symReq), .symOut(symOut), .extData(extData), .extSync(extSync)
  );
  sqf_mod_model i_mod (
    .clock(clock), .frameSync(frameSync), .symReq(symReq), .symOut(symOut)
  );
  // one single transfer; waits on the slave, never on a fixed count
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask
  // read and compare the whole word, upper lanes must be zero
  task automatic rdc(input string nm, input logic [9:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, rdv);
    `CHK(nm, {24'h0, exp}, rdv)
  endtask
  // access start first, then the ten bytes in order
  task automatic rdBank(input logic sel);
    wr(ADR_START, {sel, 7'h00});
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, ADR_DATA, 8'h00, rdv);
      got[i] = rdv[7:0];
    end
  endtask
  // Q byte k of the captured frame, MSB first after the two sync symbols
  function automatic logic [7:0] qbyte(input int k);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[7-j] = i_mod.syms[2+8*k+j][6];
    return b;
  endfunction
  // local CRC over 80 identical Q bits, as the link frames carry
  function automatic logic [15:0] crcOf(input logic q);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 80; i++) c = {c[14:0], 1'b0} ^ ((c[15] ^ q) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // one link frame; the status read gives the pins time through the sync flops
  task automatic extFrame(input logic [7:0] d, input logic s, input logic [7:0] expStat);
    extData <= d;
    extSync <= s;
    rdc("link stat", ADR_STAT, 8'h00);
    i_mod.frame(0);
    `CHK("ext sync", 8'h00, i_mod.syms[1])
    `CHK("ext sym", d, i_mod.syms[10])
    crc = crcOf(d[6]);
    for (int i = 0; i < 16; i++) `CHK("crc bit", ~crc[15-i], i_mod.syms[82+i][6])
    rdc("sync err", ADR_STAT, expStat);
  endtask
  // verdict in one place
  task automatic summarize();
    $display("compared %0d, errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, well beyond the expected run of some 4k cycles
  initial begin
    repeat (60000) @(posedge clock);
    numErrors++;
    summarize();
  end
  // main sequence
  initial begin
    // idle bus and quiet link while reset is held
    nrst <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    extData <= 8'h00;
    extSync <= 1'b1;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rdc("cfg2 reset", ADR_CFG2, 8'h00);
    rdc("unmapped", 10'h3FC, 8'h00);
    // load both banks, then read the output bank back with pointer wrap
    wr(ADR_START, 8'h80);
    for (int i = 0; i < 10; i++) wr(ADR_DATA, bankA[i]);
    wr(ADR_START, 8'h00);
    for (int i = 0; i < 10; i++) wr(ADR_DATA, bankB[i]);
    rdBank(1'b1);
    for (int i = 0; i < 10; i++) `CHK("bankA", bankA[i], got[i])
    rdc("wrap", ADR_DATA, bankA[0]);
    // every time code, zero nibble counting, copy bit held
    for (int k = 0; k < 5; k++) begin
      wr(ADR_CFG1, {3'b000, codes[k][0], codes[k][1], 1'b0, 1'b1, codes[k][2]});
      i_mod.frame(0);
      rdBank(1'b1);
      `CHK("rel frame", expRel[k], got[5])
      `CHK("abs frame", expAbs[k], got[9])
      `CHK("zero byte", expZero[k], got[6])
      `CHK("ctrl held", 8'h00, got[0])
    end
    // copy alternate on, time held, zero increment off
    wr(ADR_CFG1, 8'h1D);
    i_mod.frame(0);
    rdBank(1'b1);
    `CHK("copy bit", 8'h20, got[0])
    `CHK("zero hold", 8'h32, got[6])
    // P level rewritten in mid-frame must wait for the next frame
    wr(ADR_CFG1, 8'h19);
    fork
      i_mod.frame(1);
      begin
        repeat (100) @(posedge clock);
        wr(ADR_CFG1, 8'h39);
      end
    join
    `CHK("sync sym", 8'h00, i_mod.syms[0])
    `CHK("p early", 1'b0, i_mod.syms[2][7])
    `CHK("p late", 1'b0, i_mod.syms[97][7])
    `CHK("r to w", 6'h00, i_mod.syms[10][5:0])
    `CHK("q byte1", 8'hA5, qbyte(1))
    i_mod.frame(0);
    `CHK("p level", 1'b1, i_mod.syms[2][7])
    // follow-frame: abs frame 0x07 has bit 5 clear
    wr(ADR_CFG1, 8'h79);
    i_mod.frame(0);
    `CHK("p follow", 1'b0, i_mod.syms[50][7])
    wr(ADR_CFG1, 8'h19);
    // reload field, counting and wrap
    wr(ADR_CFG2, 8'h28);
    rdc("cnt load", ADR_CFG2, 8'h2D);
    i_mod.frame(0);
    rdc("cnt step", ADR_CFG2, 8'h2E);
    wr(ADR_CFG2, 8'h38);
    i_mod.frame(0);
    rdc("cnt wrap", ADR_CFG2, 8'h38);
    // swap without insert-once, then insert-once without swap: no switch
    wr(ADR_CFG2, 8'h80);
    i_mod.frame(0);
    `CHK("no insert", 8'hA5, qbyte(1))
    wr(ADR_CFG2, 8'h40);
    i_mod.frame(0);
    `CHK("no swap", 8'hA5, qbyte(1))
    // swap plus insert-once at count zero: other bank for one frame
    wr(ADR_CFG2, 8'hC0);
    i_mod.frame(0);
    `CHK("inserted", 8'h5A, qbyte(1))
    rdc("stat other", ADR_STAT, 8'h02);
    rdBank(1'b1);
    `CHK("sel out", 8'h5A, got[1])
    rdBank(1'b0);
    `CHK("sel other", 8'hA5, got[1])
    rdc("ins clear", ADR_CFG2, 8'h81);
    i_mod.frame(0);
    `CHK("once only", 8'hA5, qbyte(1))
    // external link: sync present, then sync missing; link symbols pass, CRC local
    wr(ADR_CFG1, 8'h80);
    extFrame(8'h2A, 1'b1, 8'h00);
    extFrame(8'hD5, 1'b0, 8'h01);
    wr(ADR_STAT, 8'h01);
    rdc("sync clear", ADR_STAT, 8'h00);
    rdBank(1'b1);
    `CHK("ext hold", 8'h06, got[5])
    summarize();
  end
endmodule // subcode_q_channel_formatter_tb
